// ===== verilog/rfsm_top.sv
module rfsm_top
  import rfsm_pkg::*;
#(
  parameter logic [7:0] MASK1_RESET = RFSM_MASK1_RST,
  parameter logic [7:0] MASK2_RESET = RFSM_MASK2_RST
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port from the serial control logic
  input wire rfsm_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Rail fault levels from the regulators
  input wire logic [RFSM_RAIL_COUNT-1:0] rail_fault,
  // Shutdown request to the sequencer
  output logic shutdown_req
);

  rfsm_state_t st_r;
  rfsm_state_t st_nxt;
  logic [RFSM_RAIL_COUNT-1:0] flt_s;
  logic [RFSM_RAIL_COUNT-1:0] flt_live;

  rfsm_fault_sync #(
    .WIDTH(RFSM_RAIL_COUNT)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .fault_async(rail_fault),
    .fault_sync(flt_s)
  );

  // Per-rail gate: a set bit of the first mask keeps that fault off the shutdown path
  genvar gi;
  generate
    for (gi = 0; gi < RFSM_RAIL_COUNT; gi++) begin : g_gate
      assign flt_live[gi] =
        flt_s[gi] & ~st_r.mask1[gi];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    if (reg_req.wr && reg_req.addr == RFSM_MASK1_ADDR) begin
      st_nxt.mask1 = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == RFSM_MASK2_ADDR) begin
      st_nxt.mask2 = reg_req.wdata & RFSM_MASK2_WMASK;
    end
    case (reg_req.addr)
      RFSM_MASK1_ADDR: st_nxt.rdata = st_r.mask1;
      RFSM_MASK2_ADDR: st_nxt.rdata = st_r.mask2;
      default: st_nxt.rdata = RFSM_UNMAPPED_RD;
    endcase
    st_nxt.shutdown = |flt_live;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r.mask1 <= MASK1_RESET;
      st_r.mask2 <= MASK2_RESET;
      st_r.rdata <= RFSM_RDATA_RST;
      st_r.shutdown <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign shutdown_req = st_r.shutdown;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  linear_two_pass_a: assert property (
    flt_s[RFSM_BIT_LINEAR_A_TWO] && !st_r.mask1[RFSM_BIT_LINEAR_A_TWO]
      |=> shutdown_req)
    else $error("linear A two fault did not request shutdown");

  linear_two_block_a: assert property (
    flt_s == 8'h80 && st_r.mask1[RFSM_BIT_LINEAR_A_TWO] |=> !shutdown_req)
    else $error("masked linear A two fault requested shutdown");

  switch_one_pass_a: assert property (
    flt_s[RFSM_BIT_SWITCH_A_ONE] && !st_r.mask1[RFSM_BIT_SWITCH_A_ONE]
      |=> shutdown_req)
    else $error("switch A one fault did not request shutdown");

  switch_one_block_a: assert property (
    flt_s == 8'h40 && st_r.mask1[RFSM_BIT_SWITCH_A_ONE] |=> !shutdown_req)
    else $error("masked switch A one fault requested shutdown");

  rail_six_gate_a: assert property (
    flt_s == 8'h20 |=> shutdown_req == !$past(st_r.mask1[5]))
    else $error("step-down six gate wrong");

  rail_five_gate_a: assert property (
    flt_s == 8'h10 |=> shutdown_req == !$past(st_r.mask1[4]))
    else $error("step-down five gate wrong");

  rail_four_gate_a: assert property (
    flt_s == 8'h08 ##1 flt_s == 8'h08 && $stable(st_r.mask1)
      |=> shutdown_req == !$past(st_r.mask1[RFSM_BIT_STEP_DOWN_FOUR]))
    else $error("step-down four gate wrong");

  rail_three_gate_a: assert property (
    flt_s == 8'h04 |=> shutdown_req == !$past(st_r.mask1[2]))
    else $error("step-down three gate wrong");

  rail_two_gate_a: assert property (
    flt_s == 8'h02 |=> shutdown_req == !$past(st_r.mask1[1]))
    else $error("step-down two gate wrong");

  rail_one_gate_a: assert property (
    flt_s == 8'h01 |=> shutdown_req == !$past(st_r.mask1[0]))
    else $error("step-down one gate wrong");

  mask2_write_a: assert property (
    reg_req.wr && reg_req.addr == RFSM_MASK2_ADDR
      |=> st_r.mask2 == ($past(reg_req.wdata) & RFSM_MASK2_WMASK)
      ##1 reg_rdata == $past(st_r.mask2) || $past(reg_req.addr) != 8'hA3)
    else $error("second mask write or readback wrong");

  mask2_top_zero_a: assert property (
    reg_req.addr == RFSM_MASK2_ADDR |=> !reg_rdata[7])
    else $error("second mask bit 7 not read as zero");

  shutdown_or_a: assert property (
    1'b1 |=> shutdown_req == $past(|(flt_s & ~st_r.mask1)))
    else $error("shutdown request is not the OR of live faults");

  no_fault_quiet_a: assert property (
    (flt_s == 8'h00) [*2] |-> !shutdown_req)
    else $error("shutdown requested with no fault present");

  mask1_write_a: assert property (
    reg_req.wr && reg_req.addr == RFSM_MASK1_ADDR
      |=> st_r.mask1 == $past(reg_req.wdata))
    else $error("first mask write not stored");

  mask1_hold_a: assert property (
    !(reg_req.wr && reg_req.addr == RFSM_MASK1_ADDR)
      |=> $stable(st_r.mask1))
    else $error("first mask changed without a write");

  mask2_hold_a: assert property (
    !(reg_req.wr && reg_req.addr == RFSM_MASK2_ADDR)
      |=> $stable(st_r.mask2))
    else $error("second mask changed without a write");

  mask1_read_a: assert property (
    reg_req.addr == RFSM_MASK1_ADDR |=> reg_rdata == $past(st_r.mask1))
    else $error("first mask read back wrong");

  mask2_read_a: assert property (
    reg_req.addr == RFSM_MASK2_ADDR |=> reg_rdata == $past(st_r.mask2))
    else $error("second mask read back wrong");

  unmapped_read_a: assert property (
    reg_req.addr != RFSM_MASK1_ADDR && reg_req.addr != RFSM_MASK2_ADDR
      |=> reg_rdata == RFSM_UNMAPPED_RD)
    else $error("unmapped offset read not zero");

  mask2_bit7_zero_a: assert property (
    1'b1 |-> !st_r.mask2[7])
    else $error("second mask bit 7 stored as one");

  all_masked_quiet_a: assert property (
    st_r.mask1 == 8'hFF |=> !shutdown_req)
    else $error("shutdown requested with every rail masked");

  live_fault_raise_a: assert property (
    (flt_s & ~st_r.mask1) != 8'h00 |=> shutdown_req)
    else $error("unmasked fault did not request shutdown");

  masked_quiet_a: assert property (
    (flt_s & ~st_r.mask1) == 8'h00 |=> !shutdown_req)
    else $error("shutdown requested with only masked faults");

  request_rise_a: assert property (
    $rose(shutdown_req) |-> $past((flt_s & ~st_r.mask1) != 8'h00))
    else $error("shutdown request rose with no live fault");

  request_fall_a: assert property (
    $fell(shutdown_req) |-> $past((flt_s & ~st_r.mask1) == 8'h00))
    else $error("shutdown request fell with a live fault");

  request_steady_a: assert property (
    $stable(flt_s) && $stable(st_r.mask1)
      |=> $stable(shutdown_req))
    else $error("shutdown request moved with no cause");

  fault_sync_lag_a: assert property (
    1'b1 |=> ##1 flt_s == $past(rail_fault, 2))
    else $error("fault levels not delayed by two stages");

  rail_six_pass_a: assert property (
    flt_s[RFSM_BIT_STEP_DOWN_SIX] && !st_r.mask1[RFSM_BIT_STEP_DOWN_SIX]
      |=> shutdown_req)
    else $error("step-down six fault did not request shutdown");

  rail_four_pass_a: assert property (
    flt_s[RFSM_BIT_STEP_DOWN_FOUR] && !st_r.mask1[RFSM_BIT_STEP_DOWN_FOUR]
      |=> shutdown_req)
    else $error("step-down four fault did not request shutdown");

  rail_two_pass_a: assert property (
    flt_s[RFSM_BIT_STEP_DOWN_TWO] && !st_r.mask1[RFSM_BIT_STEP_DOWN_TWO]
      |=> shutdown_req)
    else $error("step-down two fault did not request shutdown");

  rail_one_pass_a: assert property (
    flt_s[RFSM_BIT_STEP_DOWN_ONE] && !st_r.mask1[RFSM_BIT_STEP_DOWN_ONE]
      |=> shutdown_req)
    else $error("step-down one fault did not request shutdown");

endmodule // rfsm_top

// ===== inc/rfsm_pkg.sv
package rfsm_pkg;

  // Register offsets on the device's internal register port
  localparam logic [7:0] RFSM_MASK1_ADDR = 8'hA2;
  localparam logic [7:0] RFSM_MASK2_ADDR = 8'hA3;

  // Reset values vary by factory option; these are the plain defaults
  localparam logic [7:0] RFSM_MASK1_RST = 8'h00;
  localparam logic [7:0] RFSM_MASK2_RST = 8'h20;

  // Writable bits of the second mask register (bit 7 reads as zero)
  localparam logic [7:0] RFSM_MASK2_WMASK = 8'h7F;

  // Read answer for an unmapped offset
  localparam logic [7:0] RFSM_UNMAPPED_RD = 8'h00;

  // Read data register value while reset is held
  localparam logic [7:0] RFSM_RDATA_RST = 8'h00;

  // Bit positions of the first mask register and of the fault vector
  localparam int RFSM_BIT_LINEAR_A_TWO = 7;
  localparam int RFSM_BIT_SWITCH_A_ONE = 6;
  localparam int RFSM_BIT_STEP_DOWN_SIX = 5;
  localparam int RFSM_BIT_STEP_DOWN_FIVE = 4;
  localparam int RFSM_BIT_STEP_DOWN_FOUR = 3;
  localparam int RFSM_BIT_STEP_DOWN_THREE = 2;
  localparam int RFSM_BIT_STEP_DOWN_TWO = 1;
  localparam int RFSM_BIT_STEP_DOWN_ONE = 0;

  localparam int RFSM_RAIL_COUNT = 8;

  // One register access from the serial control logic
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfsm_reg_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] rdata;
    logic shutdown;
  } rfsm_state_t;

endpackage

// ===== verilog/rfsm_fault_sync.sv
module rfsm_fault_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous fault levels in, synchronised levels out
  input wire logic [WIDTH-1:0] fault_async,
  output logic [WIDTH-1:0] fault_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rfsm_sync_state_t;

  rfsm_sync_state_t st_r;
  rfsm_sync_state_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = fault_async;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fault_sync = st_r.stable;

endmodule // rfsm_fault_sync

// ===== test/rfsm_host_model.sv
module rfsm_host_model
  import rfsm_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output rfsm_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial reg_req = '0;

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    if (a == RFSM_MASK2_ADDR) d = (d & 8'hBF) | 8'h20;
    reg_req = '{1'b1, a, d};
    @(posedge clock);
    #1;
    reg_req.wr = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_req = '{1'b0, a, 8'h00};
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask
endmodule // rfsm_host_model

// ===== test/tb_rail_fault_shutdown_mask.sv
module tb_rail_fault_shutdown_mask;
  import rfsm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  miscompares++; $display("Error at %0t: got %0h exp %0h", $time, a, e); \
  end end
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  rfsm_reg_req_t reg_req;
  logic [7:0] reg_rdata, m, f, d;
  logic [7:0] rail_fault = 8'h00;
  logic shutdown_req;
  int miscompares = 0;
  int check_count = 0;
  int seed = 59059;

  always #2.5 clock = ~clock;

  rfsm_top DUT (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rail_fault(rail_fault),
    .shutdown_req(shutdown_req));
  rfsm_host_model host (.clock(clock), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  function automatic logic exp_sd(logic [7:0] flt, logic [7:0] msk);
    return |(flt & ~msk);
  endfunction

  task automatic end_of_test();
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Set mask, then faults, and wait out the two-stage synchroniser
  task automatic apply(input logic [7:0] mm, input logic [7:0] ff);
    host.wr_reg(RFSM_MASK1_ADDR, mm);
    rail_fault = ff;
    repeat (4) @(posedge clock);
    #1;
    `CHK(shutdown_req, exp_sd(ff, mm))
  endtask

  initial begin
    repeat (2) @(posedge clock);
    #1;
    `CHK(shutdown_req, 1'b0)
    rst_n = 1'b1;
    host.rd_reg(RFSM_MASK1_ADDR, d);
    `CHK(d, RFSM_MASK1_RST)
    host.rd_reg(RFSM_MASK2_ADDR, d);
    `CHK(d, RFSM_MASK2_RST)
    host.rd_reg(8'hA4, d);
    `CHK(d, RFSM_UNMAPPED_RD)
    host.wr_reg(RFSM_MASK2_ADDR, 8'hDF);
    host.rd_reg(RFSM_MASK2_ADDR, d);
    `CHK(d, 8'h3F)
    host.wr_reg(8'hA4, 8'h55);
    host.rd_reg(RFSM_MASK1_ADDR, d);
    `CHK(d, RFSM_MASK1_RST)
    host.rd_reg(RFSM_MASK2_ADDR, d);
    `CHK(d, 8'h3F)
    for (int i = 0; i < 8; i++) begin
      apply(~(8'h01 << i), 8'h01 << i);
      apply(8'hFF, 8'h01 << i);
    end
    repeat (64) begin
      m = 8'($random(seed));
      f = 8'($random(seed));
      apply(m, f);
      host.rd_reg(RFSM_MASK1_ADDR, d);
      `CHK(d, m)
      host.wr_reg(RFSM_MASK2_ADDR, f);
      host.rd_reg(RFSM_MASK2_ADDR, d);
      `CHK(d, ((f & 8'hBF) | 8'h20) & RFSM_MASK2_WMASK)
    end
    // Reset in mid-run restores both masks and drops the request
    apply(8'h00, 8'h81);
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(shutdown_req, 1'b0)
    rst_n = 1'b1;
    host.rd_reg(RFSM_MASK1_ADDR, d);
    `CHK(d, RFSM_MASK1_RST)
    host.rd_reg(RFSM_MASK2_ADDR, d);
    `CHK(d, RFSM_MASK2_RST)
    `CHK(shutdown_req, exp_sd(8'h81, RFSM_MASK1_RST))
    end_of_test();
  end

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule // tb_rail_fault_shutdown_mask
